/* File: rtl/serial_pin_select_regs.vh */
// Register offsets, field positions, reset values for the serial pin selector
`ifndef SERIAL_PIN_SELECT_REGS_VH
`define SERIAL_PIN_SELECT_REGS_VH
`define SWAP_CTRL_OFFSET   12'hf57
`define SEL_CTRL_OFFSET    12'hfcb
`define SWAP_CTRL_RESET    8'h00
`define SEL_CTRL_RESET     8'h00
`define SWAP_CTRL_MASK     8'h03
`define SEL_CTRL_MASK      8'hd3
`define UNIT0_SWAP_BIT     0
`define UNIT1_SWAP_BIT     1
`define PAIR_LSB           0
`define PAIR_MSB           1
`define PIN_GROUP_BIT      4
`define TIMER_LSB          6
`define TIMER_MSB          7
`define MODE_ASYNC_TWI     2'h0
`define MODE_ASYNC_SYNC    2'h1
`define MODE_SYNC_TWI      2'h2
`define MODE_RESERVED      2'h3
`endif

/* File: rtl/serial_route_decode.v */
// Combinational pin and interrupt routing for the serial selector
`timescale 1ns/1ps
`default_nettype none
`include "serial_pin_select_regs.vh"
module serial_route_decode (
    input  wire [7:0] sel_i,
    input  wire [1:0] swap_i,
    input  wire       async0_tx_i,
    input  wire       sync_out_i,
    input  wire       sync_clk_out_i,
    input  wire       twi_sda_out_i,
    input  wire       twi_scl_out_i,
    input  wire [2:0] p2_lo_i,
    input  wire [2:0] p2_hi_i,
    input  wire [2:0] pb_i,
    input  wire [1:0] p9_i,
    input  wire       async1_tx_i,
    input  wire       tx_irq_i,
    input  wire       rx_irq_i,
    input  wire       sync_irq_i,
    input  wire       twi_irq_i,
    output reg  [2:0] p2_lo_fn_o,
    output reg  [2:0] p2_lo_val_o,
    output reg  [2:0] p2_hi_fn_o,
    output reg  [2:0] p2_hi_val_o,
    output reg  [2:0] pb_fn_o,
    output reg  [2:0] pb_val_o,
    output reg  [1:0] p9_val_o,
    output reg        async0_rx_o,
    output reg        async1_rx_o,
    output reg        sync_in_o,
    output reg        twi_sda_in_o,
    output reg        twi_scl_in_o,
    output reg        latch7_o,
    output reg        latch6_o,
    output reg        latch15_o,
    output reg  [1:0] timer_src_o
);
    wire [1:0] mode  = sel_i[`PAIR_MSB:`PAIR_LSB];
    wire       grp   = sel_i[`PIN_GROUP_BIT];
    wire       sw0   = swap_i[`UNIT0_SWAP_BIT];
    reg  [2:0] grp_fn;
    reg  [2:0] grp_val;
    reg  [2:0] grp_in;

    // Route units onto pin groups and decode interrupt latches
    always @* begin
        grp_fn       = 3'h0;
        grp_val      = 3'h0;
        p2_hi_fn_o   = 3'h0;
        p2_hi_val_o  = 3'h0;
        async0_rx_o  = 1'b1;
        sync_in_o    = 1'b0;
        twi_sda_in_o = 1'b1;
        twi_scl_in_o = 1'b1;
        latch7_o     = 1'b0;
        latch6_o     = 1'b0;
        latch15_o    = 1'b0;
        grp_in       = grp ? pb_i : p2_lo_i;                        // [R4] [R5]
        case (mode)                                                 // [R1] [R3]
            `MODE_ASYNC_TWI, `MODE_ASYNC_SYNC: begin
                // Async unit0 on group: tx on first pin unless swapped
                grp_fn      = 3'b011;
                grp_val     = sw0 ? {1'b0, async0_tx_i, 1'b0} : {2'b00, async0_tx_i}; // [R6]
                async0_rx_o = sw0 ? grp_in[0] : grp_in[1];          // [R6]
                latch7_o    = tx_irq_i;                             // [R8]
                latch6_o    = rx_irq_i;
                if (mode == `MODE_ASYNC_TWI) begin
                    p2_hi_fn_o   = 3'b011;                          // [R13]
                    p2_hi_val_o  = {1'b0, twi_scl_out_i, twi_sda_out_i};
                    twi_sda_in_o = p2_hi_i[0];
                    twi_scl_in_o = p2_hi_i[1];
                    latch15_o    = twi_irq_i;
                end else begin
                    p2_hi_fn_o  = 3'b111;                           // [R14] Out, in, clock owned
                    p2_hi_val_o = {sync_clk_out_i, 1'b0, sync_out_i};
                    sync_in_o   = p2_hi_i[1];
                    latch15_o   = sync_irq_i;
                end
            end
            `MODE_SYNC_TWI: begin
                grp_fn       = 3'b111;                              // [R5] Out, in, clock owned
                grp_val      = {sync_clk_out_i, 1'b0, sync_out_i};
                sync_in_o    = grp_in[1];
                p2_hi_fn_o   = 3'b011;                              // [R13]
                p2_hi_val_o  = {1'b0, twi_scl_out_i, twi_sda_out_i};
                twi_sda_in_o = p2_hi_i[0];
                twi_scl_in_o = p2_hi_i[1];
                latch6_o     = sync_irq_i;                          // [R8]
                latch15_o    = twi_irq_i;
            end
            default: begin
                grp_fn = 3'h0;                                      // Reserved: all pins free
            end
        endcase
        // Unused group keeps port function [R12]
        p2_lo_fn_o  = grp ? 3'h0 : grp_fn;
        p2_lo_val_o = grp ? 3'h0 : grp_val;
        pb_fn_o     = grp ? grp_fn : 3'h0;
        pb_val_o    = grp ? grp_val : 3'h0;
        // Async unit1 on port 9 with optional swap
        p9_val_o    = swap_i[`UNIT1_SWAP_BIT] ? {async1_tx_i, 1'b0} : {1'b0, async1_tx_i}; // [R7]
        async1_rx_o = swap_i[`UNIT1_SWAP_BIT] ? p9_i[0] : p9_i[1];  // [R7]
        timer_src_o = sel_i[`TIMER_MSB:`TIMER_LSB];                  // [R2] [R15]
    end
endmodule
`default_nettype wire

/* File: rtl/serial_pin_interrupt_selector.v */
// Serial pin and interrupt selector with Wishbone register access
// Contract
// (R1) Two of three serial units are active at once, chosen by a two-bit pair field.
// (R2) Software picks the timer counter input pin with a two-bit field in the top bits.
// (R3) Pair 00 is async plus two-wire, 01 async plus sync, 10 sync plus two-wire, 11 reserved.
// (R4) Pin group 0 routes the async or sync signals to port 2 bits 0 to 2.
// (R5) Pin group 1 routes them to port B bits 4 to 6, sync as out, in, clock.
// (R6) Unit0 swap bit 0 puts receive on the second pin, 1 swaps the pins.
// (R7) Unit1 swap bit 0 receives on port 9 bit 1 and sends on bit 0, 1 swaps.
// (R8) Latches 7, 6 and 15 take the shared interrupt sources per mode.
// (R9) Software changes the selection only while units and timer are stopped.
// (R10) Software should clear the affected latch right after changing the selection.
// (R11) Software changes the swap register only while async units are stopped.
// (R12) Pins left unassigned stay ordinary port pins.
// (R13) In modes 00 and 10 two-wire data and clock use port 2 bits 3 and 4.
// (R14) In mode 01 sync out, in and clock use port 2 bits 3, 4 and 5.
// (R15) Timer field 00 selects port 7 bit 2; 11 is reserved.
//
// Decided for this implementation: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
`include "serial_pin_select_regs.vh"
module serial_pin_interrupt_selector (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        ce_i,
    // Wishbone classic slave
    input  wire        cyc_i,
    input  wire        stb_i,
    input  wire        we_i,
    input  wire [11:0] adr_i,
    input  wire [7:0]  dat_i,
    input  wire        sel_i,
    output reg  [7:0]  dat_o,
    output reg         ack_o,
    // Unit side, same clock
    input  wire        async0_tx_i,
    input  wire        async1_tx_i,
    input  wire        sync_out_i,
    input  wire        sync_clk_out_i,
    input  wire        twi_sda_out_i,
    input  wire        twi_scl_out_i,
    input  wire        tx_irq_i,
    input  wire        rx_irq_i,
    input  wire        sync_irq_i,
    input  wire        twi_irq_i,
    // Pins from outside
    input  wire [2:0]  p2_lo_pin_i,
    input  wire [2:0]  p2_hi_pin_i,
    input  wire [2:0]  pb_pin_i,
    input  wire [1:0]  p9_pin_i,
    // Routed results
    output reg  [2:0]  p2_lo_fn_o,
    output reg  [2:0]  p2_lo_val_o,
    output reg  [2:0]  p2_hi_fn_o,
    output reg  [2:0]  p2_hi_val_o,
    output reg  [2:0]  pb_fn_o,
    output reg  [2:0]  pb_val_o,
    output reg  [1:0]  p9_val_o,
    output reg         async0_rx_o,
    output reg         async1_rx_o,
    output reg         sync_in_o,
    output reg         twi_sda_in_o,
    output reg         twi_scl_in_o,
    output reg         latch7_o,
    output reg         latch6_o,
    output reg         latch15_o,
    output reg  [1:0]  timer_src_o
);
    //------------------------------------------------------------
    // Registers and synchronisers
    //------------------------------------------------------------
    reg  [7:0]  sel_ctrl_r;
    reg  [7:0]  swap_ctrl_r;
    reg  [10:0] pin_s1_r;
    reg  [10:0] pin_s2_r;
    wire        req = cyc_i & stb_i & ~ack_o;
    wire        wr_take  = cyc_i & stb_i & we_i & sel_i & ack_o;
    wire        hit_sel  = (adr_i == `SEL_CTRL_OFFSET);
    wire        hit_swap = (adr_i == `SWAP_CTRL_OFFSET);

    // Two-stage capture of pin levels
    always @(posedge clk_i) begin
        if (rst_i) begin
            pin_s1_r <= 11'h000;
            pin_s2_r <= 11'h000;
        end else if (ce_i) begin
            pin_s1_r <= {p9_pin_i, pb_pin_i, p2_hi_pin_i, p2_lo_pin_i};
            pin_s2_r <= pin_s1_r;
        end
    end

    //------------------------------------------------------------
    // Wishbone access, registered ack after one wait cycle
    //------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            sel_ctrl_r  <= `SEL_CTRL_RESET;
            swap_ctrl_r <= `SWAP_CTRL_RESET;
            ack_o       <= 1'b0;
            dat_o       <= 8'h00;
        end else if (ce_i) begin
            ack_o <= req;
            if (req)
                dat_o <= hit_sel ? sel_ctrl_r : (hit_swap ? swap_ctrl_r : 8'h00);
            // Writes land at the edge where the master samples ack high
            if (wr_take && hit_sel)
                sel_ctrl_r <= dat_i & `SEL_CTRL_MASK;                // [R1] [R2]
            if (wr_take && hit_swap)
                swap_ctrl_r <= dat_i & `SWAP_CTRL_MASK;              // [R6] [R7]
        end
    end

    //------------------------------------------------------------
    // Routing
    //------------------------------------------------------------
    wire [2:0] p2lf, p2lv, p2hf, p2hv, pbf, pbv;
    wire [1:0] p9v, tsrc;
    wire       a0rx, a1rx, sin, sdai, scli, l7, l6, l15;

    serial_route_decode u_dec (
        .sel_i          (sel_ctrl_r),
        .swap_i         (swap_ctrl_r[1:0]),
        .async0_tx_i    (async0_tx_i),
        .sync_out_i     (sync_out_i),
        .sync_clk_out_i (sync_clk_out_i),
        .twi_sda_out_i  (twi_sda_out_i),
        .twi_scl_out_i  (twi_scl_out_i),
        .p2_lo_i        (pin_s2_r[2:0]),
        .p2_hi_i        (pin_s2_r[5:3]),
        .pb_i           (pin_s2_r[8:6]),
        .p9_i           (pin_s2_r[10:9]),
        .async1_tx_i    (async1_tx_i),
        .tx_irq_i       (tx_irq_i),
        .rx_irq_i       (rx_irq_i),
        .sync_irq_i     (sync_irq_i),
        .twi_irq_i      (twi_irq_i),
        .p2_lo_fn_o     (p2lf),
        .p2_lo_val_o    (p2lv),
        .p2_hi_fn_o     (p2hf),
        .p2_hi_val_o    (p2hv),
        .pb_fn_o        (pbf),
        .pb_val_o       (pbv),
        .p9_val_o       (p9v),
        .async0_rx_o    (a0rx),
        .async1_rx_o    (a1rx),
        .sync_in_o      (sin),
        .twi_sda_in_o   (sdai),
        .twi_scl_in_o   (scli),
        .latch7_o       (l7),
        .latch6_o       (l6),
        .latch15_o      (l15),
        .timer_src_o    (tsrc)
    );

    // Register every routed output
    always @(posedge clk_i) begin
        if (rst_i) begin
            p2_lo_fn_o   <= 3'h0;
            p2_lo_val_o  <= 3'h0;
            p2_hi_fn_o   <= 3'h0;
            p2_hi_val_o  <= 3'h0;
            pb_fn_o      <= 3'h0;
            pb_val_o     <= 3'h0;
            p9_val_o     <= 2'h0;
            async0_rx_o  <= 1'b1;
            async1_rx_o  <= 1'b1;
            sync_in_o    <= 1'b0;
            twi_sda_in_o <= 1'b1;
            twi_scl_in_o <= 1'b1;
            latch7_o     <= 1'b0;
            latch6_o     <= 1'b0;
            latch15_o    <= 1'b0;
            timer_src_o  <= 2'h0;
        end else if (ce_i) begin
            p2_lo_fn_o   <= p2lf;                                    // [R4] [R12]
            p2_lo_val_o  <= p2lv;
            p2_hi_fn_o   <= p2hf;                                    // [R13] [R14]
            p2_hi_val_o  <= p2hv;
            pb_fn_o      <= pbf;                                     // [R5]
            pb_val_o     <= pbv;
            p9_val_o     <= p9v;                                     // [R7]
            async0_rx_o  <= a0rx;
            async1_rx_o  <= a1rx;
            sync_in_o    <= sin;
            twi_sda_in_o <= sdai;
            twi_scl_in_o <= scli;
            latch7_o     <= l7;                                      // [R8]
            latch6_o     <= l6;
            latch15_o    <= l15;
            timer_src_o  <= tsrc;                                    // [R15]
        end
    end
endmodule
`default_nettype wire

/* File: verif/serial_selector_assertions.sv */
// Port-level checks for the serial pin and interrupt selector
`timescale 1ns/1ps
`default_nettype none
`include "serial_pin_select_regs.vh"
module serial_selector_checker (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [11:0] adr_i,
    input wire logic [7:0]  dat_i,
    input wire logic        sel_i,
    input wire logic [7:0]  dat_o,
    input wire logic        ack_o,
    input wire logic        async1_tx_i,
    input wire logic        tx_irq_i,
    input wire logic        twi_irq_i,
    input wire logic [2:0]  p2_hi_fn_o,
    input wire logic [2:0]  pb_fn_o,
    input wire logic [1:0]  p9_val_o,
    input wire logic        latch7_o,
    input wire logic        latch15_o,
    input wire logic [1:0]  timer_src_o
);
    logic [7:0] sel_r;
    logic [1:0] swap_r;
    logic       rst_d_r;
    logic       ce_d_r;
    wire        wr_ok = cyc_i && stb_i && we_i && sel_i && ack_o;
    wire  [1:0] mode  = sel_r[1:0];
    // Shadow copies of both registers, updated at the acknowledged edge
    always @(posedge clk_i) begin
        rst_d_r <= rst_i;
        ce_d_r  <= ce_i;
        if (rst_i) begin
            sel_r  <= 8'h00;
            swap_r <= 2'h0;
        end else if (wr_ok && adr_i == `SEL_CTRL_OFFSET) begin
            sel_r <= dat_i & `SEL_CTRL_MASK;
        end else if (wr_ok && adr_i == `SWAP_CTRL_OFFSET) begin
            swap_r <= dat_i[1:0];
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i || rst_d_r || !ce_i || !ce_d_r);
    ack_one_cycle_a: assert property (ack_o |=> !ack_o)
        else $error("ack held for more than one cycle");
    ack_answer_a: assert property (cyc_i && stb_i && ce_i && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");
    sel_readback_a: assert property (ack_o && !we_i && adr_i == `SEL_CTRL_OFFSET |-> dat_o == sel_r)
        else $error("select register read back wrong");
    timer_field_a: assert property (timer_src_o == $past(sel_r[7:6]))
        else $error("timer input select differs from field");
    reserved_mode_a: assert property ($past(mode) == 2'h3 |-> p2_hi_fn_o == 3'h0 && pb_fn_o == 3'h0 && !latch7_o && !latch15_o)
        else $error("reserved mode routes something");
    latch7_src_a: assert property (latch7_o == ($past(mode) < 2'h2 && $past(tx_irq_i)))
        else $error("latch 7 source wrong");
    latch15_src_a: assert property ($past(mode) != 2'h1 |-> latch15_o == ($past(mode) != 2'h3 && $past(twi_irq_i)))
        else $error("latch 15 source wrong");
    unit1_swap_a: assert property (p9_val_o == ($past(swap_r[1]) ? {$past(async1_tx_i), 1'b0} : {1'b0, $past(async1_tx_i)}))
        else $error("unit 1 transmit on wrong pin");
    twi_pins_a: assert property ($past(mode) == 2'h0 || $past(mode) == 2'h2 |-> p2_hi_fn_o == 3'h3)
        else $error("two-wire pins not owned");
    group_idle_a: assert property (!$past(sel_r[4]) |-> pb_fn_o == 3'h0)
        else $error("unselected group not released");
    cover property ($past(mode) == 2'h1 && p2_hi_fn_o == 3'h7);
    cover property ($past(mode) == 2'h2 && $past(sel_r[4]) && pb_fn_o == 3'h7);
    cover property (ack_o && !we_i && adr_i == 12'h123);
endmodule
bind serial_pin_interrupt_selector serial_selector_checker u_serial_selector_checker (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
    .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
    .async1_tx_i(async1_tx_i), .tx_irq_i(tx_irq_i), .twi_irq_i(twi_irq_i),
    .p2_hi_fn_o(p2_hi_fn_o), .pb_fn_o(pb_fn_o), .p9_val_o(p9_val_o), .latch7_o(latch7_o),
    .latch15_o(latch15_o), .timer_src_o(timer_src_o));
`default_nettype wire

/* File: verif/serial_far_side.sv */
// Model of the serial units, their interrupt requests and the pin levels
`timescale 1ns/1ps
`default_nettype none
module serial_far_side (
    input  wire logic        clk_i,
    input  wire logic        run_i,
    input  wire logic [20:0] lvl_i,
    output var  logic [20:0] out_o
);
    initial out_o = 21'h000000;
    // Levels only move while units run; stopped units drop their requests
    always @(posedge clk_i) begin
        if (run_i)
            out_o <= lvl_i;
        else
            out_o <= out_o & ~21'h0003c0;
    end
endmodule
`default_nettype wire

/* File: verif/tb_serial_pin_interrupt_selector.sv */
// Self-checking bench for the serial pin and interrupt selector
`timescale 1ns/1ps
`default_nettype none
`include "serial_pin_select_regs.vh"
module tb_serial_pin_interrupt_selector;
    logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
    logic        sel_i = 1'b0, run = 1'b0, ce = 1'b1;
    logic [11:0] adr_i = 12'h000;
    logic [7:0]  dat_i = 8'h00, rd, sv, wv, snap, snap2;
    logic [15:0] seed = 16'h0040;
    logic [20:0] lvl = 21'h000000;
    wire  [20:0] far;
    wire  [7:0]  dat_o;
    wire         ack_o, a0_rx, a1_rx, s_in, sda_in, scl_in, l7, l6, l15;
    wire  [2:0]  lo_fn, lo_val, hi_fn, hi_val, pb_fn, pb_val;
    wire  [1:0]  p9_val, tmr;
    integer      error_cnt = 0, check_count = 0, i;
    always #20 clk_i = ~clk_i;
    serial_far_side u_serial_far_side (.clk_i(clk_i), .run_i(run), .lvl_i(lvl), .out_o(far));
    serial_pin_interrupt_selector u_serial_pin_interrupt_selector (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
        .adr_i(adr_i), .dat_i(dat_i), .sel_i(sel_i), .dat_o(dat_o), .ack_o(ack_o),
        .async0_tx_i(far[0]), .async1_tx_i(far[1]), .sync_out_i(far[2]),
        .sync_clk_out_i(far[3]), .twi_sda_out_i(far[4]), .twi_scl_out_i(far[5]),
        .tx_irq_i(far[6]), .rx_irq_i(far[7]), .sync_irq_i(far[8]), .twi_irq_i(far[9]),
        .p2_lo_pin_i(far[12:10]), .p2_hi_pin_i(far[15:13]), .pb_pin_i(far[18:16]),
        .p9_pin_i(far[20:19]), .p2_lo_fn_o(lo_fn), .p2_lo_val_o(lo_val), .p2_hi_fn_o(hi_fn),
        .p2_hi_val_o(hi_val), .pb_fn_o(pb_fn), .pb_val_o(pb_val), .p9_val_o(p9_val),
        .async0_rx_o(a0_rx), .async1_rx_o(a1_rx), .sync_in_o(s_in), .twi_sda_in_o(sda_in),
        .twi_scl_in_o(scl_in), .latch7_o(l7), .latch6_o(l6), .latch15_o(l15),
        .timer_src_o(tmr));
    function [15:0] lfsr(input [15:0] v);
        lfsr = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task stop_test;
        if (error_cnt == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task check(input [7:0] seen, input [7:0] exp);
        check_count = check_count + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // One classic cycle: hold the request until ack is sampled high
    task bus(input [11:0] a, input w, input s, input [7:0] d);
        integer n;
        n = 0;
        @(posedge clk_i);
        {cyc_i, stb_i, we_i, sel_i, adr_i, dat_i} <= {2'b11, w, s, a, d};
        do begin
            @(posedge clk_i);
            n = n + 1;
        end while (ack_o !== 1'b1 && n < 20);
        rd = dat_o;
        if (ack_o !== 1'b1) begin
            error_cnt = error_cnt + 1;
            stop_test;
        end
        {cyc_i, stb_i, we_i} <= 3'b000;
    endtask
    // Expected routing worked out from the selection, the swap bits and the far-side levels
    task route(input [7:0] s, input [1:0] w);
        logic [1:0] m;
        logic [2:0] g, fn, val, hf, hv;
        m = s[1:0];
        g = s[4] ? far[18:16] : far[12:10];
        fn = m == 2'h3 ? 3'h0 : m == 2'h2 ? 3'h7 : 3'h3;
        val = m == 2'h3 ? 3'h0 : m == 2'h2 ? {far[3], 1'b0, far[2]} : w[0] ? {1'b0, far[0], 1'b0} : {2'b00, far[0]};
        hf = m == 2'h1 ? 3'h7 : m == 2'h3 ? 3'h0 : 3'h3;
        hv = m == 2'h1 ? {far[3], 1'b0, far[2]} : m == 2'h3 ? 3'h0 : {1'b0, far[5], far[4]};
        check({6'h00, tmr}, {6'h00, s[7:6]});
        check({2'b00, s[4] ? pb_fn : lo_fn, s[4] ? lo_fn : pb_fn}, {2'b00, fn, 3'h0});
        check({2'b00, s[4] ? pb_val : lo_val, s[4] ? lo_val : pb_val},
              {2'b00, val, 3'h0});
        check({2'b00, hi_fn, hi_val}, {2'b00, hf, hv});
        check({5'h00, l15, l6, l7}, {5'h00, m == 2'h1 ? far[8] : m != 2'h3 && far[9],
              m < 2'h2 ? far[7] : m == 2'h2 && far[8], m < 2'h2 && far[6]});
        check({5'h00, a1_rx, p9_val}, {5'h00, w[1] ? {far[19], far[1], 1'b0} : {far[20], 1'b0, far[1]}});
        if (m < 2'h2)
            check({7'h00, a0_rx}, {7'h00, w[0] ? g[0] : g[1]});
        else
            check({7'h00, a0_rx}, 8'h01);
        if (m == 2'h0 || m == 2'h3)
            check({7'h00, s_in}, 8'h00);
        if (m == 2'h2)
            check({7'h00, s_in}, {7'h00, g[1]});
        if (m == 2'h1)
            check({7'h00, s_in}, {7'h00, far[14]});
        if (m == 2'h0 || m == 2'h2)
            check({6'h00, scl_in, sda_in}, {6'h00, far[14:13]});
        else
            check({6'h00, scl_in, sda_in}, 8'h03);
    endtask
    // Registers first, then every mode, group and unit0 swap, then random selections
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(`SEL_CTRL_OFFSET, 1'b0, 1'b1, 8'h00);
        check(rd, `SEL_CTRL_RESET);
        bus(`SEL_CTRL_OFFSET, 1'b1, 1'b1, 8'hff);
        bus(`SWAP_CTRL_OFFSET, 1'b1, 1'b1, 8'hff);
        bus(`SEL_CTRL_OFFSET, 1'b1, 1'b0, 8'h00);
        bus(12'h123, 1'b1, 1'b1, 8'hff);
        bus(`SEL_CTRL_OFFSET, 1'b0, 1'b1, 8'h00);
        check(rd, 8'hd3);
        bus(`SWAP_CTRL_OFFSET, 1'b0, 1'b1, 8'h00);
        check(rd, 8'h03);
        bus(12'h123, 1'b0, 1'b1, 8'h00);
        check(rd, 8'h00);
        for (i = 0; i < 48; i = i + 1) begin
            seed = lfsr(seed);
            sv = i < 16 ? {seed[7:6], 1'b0, i[2], 2'b00, i[1:0]} : seed[7:0];
            wv = i < 16 ? {seed[15:9], i[3]} : seed[15:8];
            run <= 1'b0;
            bus(`SEL_CTRL_OFFSET, 1'b1, 1'b1, sv);
            bus(`SWAP_CTRL_OFFSET, 1'b1, 1'b1, wv);
            seed = lfsr(seed);
            lvl <= {seed[4:0], lfsr(seed)};
            run <= 1'b1;
            repeat (6) @(posedge clk_i);
            route(sv, wv[1:0]);
            // Clock enable low while every far-side level flips: latches, unit inputs and port 2 and 9 values may not move
            if (i[2:0] == 3'h7) begin
                snap  = {l15, l6, l7, a0_rx, a1_rx, s_in, sda_in, scl_in};
                snap2 = {p9_val, lo_val, hi_val};
                ce   <= 1'b0;
                lvl  <= ~lvl;
                repeat (4) @(posedge clk_i);
                check({l15, l6, l7, a0_rx, a1_rx, s_in, sda_in, scl_in}, snap);
                check({p9_val, lo_val, hi_val}, snap2);
                ce   <= 1'b1;
                repeat (6) @(posedge clk_i);
                route(sv, wv[1:0]);
            end
        end
        stop_test;
    end
    // Guard against a hung run
    initial begin
        #200000;
        error_cnt = error_cnt + 1;
        stop_test;
    end
endmodule
`default_nettype wire
